/* dcvm_chk_monitor.sv */
// port-level checks on bus, register layout and interrupt of the monitor
`timescale 1ns/100ps
`default_nettype none
module dcvm_chk_monitor import dcvm_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // bus and interrupt
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [7:0] wbAdr,
    input wire logic [31:0] wbDatOut,
    input wire logic wbAck,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence sTaken;
        wbCyc && wbStb && !wbAck;
    endsequence
    sequence sReadAck(logic [7:0] a);
        wbAck && !$past(wbWe) && $past(wbAdr) == a;
    endsequence
    a_ack_next: assert property (sTaken |=> wbAck)
        else $error("no ack after request");
    a_ack_single: assert property (wbAck |=> !wbAck)
        else $error("ack held too long");
    a_dat_idle: assert property (!wbAck |-> wbDatOut == 32'h0)
        else $error("data outside ack");
    a_unmapped_zero: assert property (wbAck && !$past(wbWe) && $past(wbAdr) >= 8'h20 |->
        wbDatOut == 32'h0) else $error("unmapped read not zero");
    a_mode_field: assert property (sReadAck(REG_CTRL) |-> wbDatOut[31:4] == 28'h0)
        else $error("control bits out of field");
    a_flag_pair: assert property (sReadAck(REG_IRQ_STAT) |-> wbDatOut[31:2] == 30'h0)
        else $error("status bits out of field");
    a_err_layout: assert property (sReadAck(REG_ERR_HOST) |-> wbDatOut[31:4] == 28'h0)
        else $error("error register bits out of field");
    a_irq_fall: assert property ($fell(irq) |-> $past(wbAck) && $past(wbWe, 2))
        else $error("irq dropped without a write");
endmodule
bind dcvm_monitor dcvm_chk_monitor dcvm_chk_monitor_i (.clk(clk), .resetn(resetn),
    .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbDatOut(wbDatOut),
    .wbAck(wbAck), .irq(irq));
`default_nettype wire

/* dcvm_cpu_model.sv */
// processor code pins and core supply converter stand-in for one cpu
`timescale 1ns/100ps
`default_nettype none
module dcvm_cpu_model #(
    parameter int STEP = 120
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // bench control
    input wire logic [6:0] target,
    input wire logic glitch,
    input wire logic [7:0] supply,
    // pins and converter result
    output logic [5:0] codePins,
    output logic bit6Pin,
    output logic [7:0] reading,
    output logic valid
);
    logic [5:0] code, lag;
    int stepWait, glitchCnt, slot;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            code <= 6'h02;
            stepWait <= 0;
            glitchCnt <= 0;
            slot <= 0;
        end else begin
            stepWait <= stepWait + 1;
            if (stepWait >= STEP && code != target[5:0]) begin
                code <= (code < target[5:0]) ? code + 6'h1 : code - 6'h1;
                stepWait <= 0;
            end
            glitchCnt <= glitch ? 50 : (glitchCnt > 0) ? glitchCnt - 1 : 0;
            slot <= (slot + 1) % 32;
        end
        // upper lines lag one cycle, so a step that changes code bits 5:3 shows a short false code
        lag <= code;
        codePins <= (glitchCnt > 0) ? ~code : {lag[5:3], code[2:0]};
        bit6Pin <= target[6];
        valid <= (slot == 0);
        // between results the bus no longer holds the value
        reading <= (slot == 0) ? supply : ~supply;
    end
endmodule
`default_nettype wire

/* dcvm_limit_check.sv */
// dynamic window comparison of one core supply reading
`timescale 1ns/100ps
`default_nettype none
module dcvm_limit_check import dcvm_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // comparison inputs
    input wire logic strobe,
    input wire logic [VOLT_W-1:0] avg,
    input wire logic offSeen,
    input wire logic [ADC_W-1:0] reading,
    input wire logic [7:0] upOffset,
    input wire logic [7:0] lowOffset,
    // result
    output logic fail
);
    logic [VOLT_W:0] upper, lower, value;
    logic upperOn, lowerOn, fail_next;

    always_comb begin
        value = (VOLT_W + 1)'(reading);
        upper = (VOLT_W + 1)'(avg) + (VOLT_W + 1)'(upOffset);
        // limits above the cap cannot be trusted, so only that side stops
        upperOn = upper <= UPPER_CAP;
        lowerOn = (VOLT_W + 1)'(avg) >= (VOLT_W + 1)'(lowOffset);
        lower = (VOLT_W + 1)'(avg) - (VOLT_W + 1)'(lowOffset);
        fail_next = 1'b0;
        if (strobe && !offSeen) begin
            fail_next = (upperOn && value > upper) || (lowerOn && value < lower);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fail <= 1'b0;
        end else begin
            fail <= fail_next;
        end
    end
endmodule
`default_nettype wire

/* dcvm_monitor.sv */
// dynamic core voltage monitor top with wishbone registers
// Notes on behaviour
// - Both core supply readings are checked against limits that follow each cpu code.
// - Three regulator families are served through four code modes set in CTRL.
// - Codes that stand for less than the skew time are never accepted.
// - Limits are built from the window average of the code voltage, not the live code.
// - Upper limit is average plus offset, lower is average minus offset; outside errs.
// - Checks run once per 100 ms period and each average spans 1.5 ms.
// - A window that saw an output-off code skips its dynamic check.
// - An upper limit above 1.5875 V switches off only the upper check.
// - In legacy mode the seventh code pin is a plain input shown in both error registers.
// - Temperature-routed analog inputs read back with the top bit inverted.
//
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
module dcvm_monitor import dcvm_pkg::*; #(
    parameter int PERIOD_CYCLES = CMP_CYCLES,
    parameter int SAMPLE_CYCLES = AVG_SAMPLE_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // wishbone slave
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [7:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatIn,
    output logic [31:0] wbDatOut,
    output logic wbAck,
    // processor voltage code pins
    input wire logic [5:0] cpuAVoltageCode,
    input wire logic [5:0] cpuBVoltageCode,
    input wire logic seventhVoltageCodeBitA,
    input wire logic seventhVoltageCodeBitB,
    // converter results
    input wire logic supplyValid,
    input wire logic [ADC_W-1:0] coreSupplyInputA,
    input wire logic [ADC_W-1:0] coreSupplyInputB,
    input wire logic tempValid,
    input wire logic [ADC_W-1:0] tempCapableInputHi,
    input wire logic [ADC_W-1:0] tempCapableInputLo,
    // interrupt
    output logic irq
);
    localparam int PW = $clog2(PERIOD_CYCLES + 1);

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        hit = adr == ofs;
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [3:0] ctrl_reg, ctrl_next;
    logic [15:0] offset_reg, offset_next;
    logic [1:0] stat_reg, stat_next;
    logic [1:0] mask_reg, mask_next;
    logic [ADC_W-1:0] supA_reg, supA_next, supB_reg, supB_next;
    logic [ADC_W-1:0] tempHi_reg, tempHi_next, tempLo_reg, tempLo_next;
    logic [PW-1:0] period_reg, period_next;
    logic winStart_reg, winStart_next;
    logic ack_reg, ack_next;
    logic [31:0] rdata_reg, rdata_next;
    logic irq_reg, irq_next;

    logic wrStrobe, rdStrobe;
    logic [1:0] fail;
    logic [1:0] gpiShown;
    logic [5:0] codeRaw [2];
    logic bit6Raw [2];
    logic [ADC_W-1:0] supply [2];
    logic [31:0] rdMux;
    logic [31:0] errWord;

    dcvm_vid_if vidBus[2] ();

    assign codeRaw[0] = cpuAVoltageCode;
    assign codeRaw[1] = cpuBVoltageCode;
    assign bit6Raw[0] = seventhVoltageCodeBitA;
    assign bit6Raw[1] = seventhVoltageCodeBitB;
    assign supply[0] = supA_reg;
    assign supply[1] = supB_reg;

    // ----------------------------------------
    // per processor filter and check
    // ----------------------------------------
    generate
        for (genvar i = 0; i < 2; i++) begin : g_cpu
            assign vidBus[i].winStart = winStart_reg;
            assign vidBus[i].mode = dcvm_mode_t'(ctrl_reg[CTRL_MODE_LSB +: 2]);

            dcvm_vid_filter #(
                .SAMPLE_CYCLES(SAMPLE_CYCLES)
            ) u_filter (
                .clk(clk),
                .resetn(resetn),
                .codePins(codeRaw[i]),
                .bit6Pin(bit6Raw[i]),
                .vidBus(vidBus[i])
            );

            // independent of any static comparison elsewhere
            dcvm_limit_check u_check (
                .clk(clk),
                .resetn(resetn),
                .strobe(vidBus[i].done),
                .avg(vidBus[i].avg),
                .offSeen(vidBus[i].offSeen),
                .reading(supply[i]),
                .upOffset(offset_reg[OFS_UP_LSB +: 8]),
                .lowOffset(offset_reg[OFS_LOW_LSB +: 8]),
                .fail(fail[i])
            );

            // pin level is only meaningful as a plain input in legacy mode
            assign gpiShown[i] = (ctrl_reg[CTRL_MODE_LSB +: 2] == DCVM_MODE_LEGACY) ?
                vidBus[i].gpiLevel : 1'b0;
        end
    endgenerate

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    assign wrStrobe = wbCyc && wbStb && wbWe && !ack_reg;
    assign rdStrobe = wbCyc && wbStb && !wbWe && !ack_reg;
    assign errWord = {28'h0000000, gpiShown, stat_reg};

    always_comb begin
        rdMux = 32'h00000000;
        if (hit(wbAdr, REG_CTRL)) begin
            rdMux = {28'h0000000, ctrl_reg};
        end else if (hit(wbAdr, REG_OFFSET)) begin
            rdMux = {16'h0000, offset_reg};
        end else if (hit(wbAdr, REG_IRQ_STAT)) begin
            rdMux = {30'h00000000, stat_reg};
        end else if (hit(wbAdr, REG_IRQ_MASK)) begin
            rdMux = {30'h00000000, mask_reg};
        end else if (hit(wbAdr, REG_ERR_HOST) || hit(wbAdr, REG_ERR_BMC)) begin
            rdMux = errWord;
        end else if (hit(wbAdr, REG_AVG)) begin
            rdMux[0 +: VOLT_W] = vidBus[0].avg;
            rdMux[AVG_B_LSB +: VOLT_W] = vidBus[1].avg;
        end else if (hit(wbAdr, REG_TEMP)) begin
            rdMux = {16'h0000, tempLo_reg, tempHi_reg};
        end
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        ctrl_next = ctrl_reg;
        offset_next = offset_reg;
        mask_next = mask_reg;
        stat_next = stat_reg;
        supA_next = supA_reg;
        supB_next = supB_reg;
        tempHi_next = tempHi_reg;
        tempLo_next = tempLo_reg;
        // one window is opened at the start of every comparison period
        if (period_reg == PW'(PERIOD_CYCLES - 1)) begin
            period_next = '0;
        end else begin
            period_next = period_reg + PW'(1);
        end
        winStart_next = period_reg == '0;
        if (supplyValid) begin
            supA_next = coreSupplyInputA;
            supB_next = coreSupplyInputB;
        end
        if (tempValid) begin
            tempHi_next = ctrl_reg[CTRL_TEMP_HI] ? tempCapableInputHi ^ SIGN_FLIP :
                tempCapableInputHi;
            tempLo_next = ctrl_reg[CTRL_TEMP_LO] ? tempCapableInputLo ^ SIGN_FLIP :
                tempCapableInputLo;
        end
        if (wrStrobe && wbSel[0]) begin
            if (hit(wbAdr, REG_CTRL)) begin
                ctrl_next = wbDatIn[3:0];
            end
            if (hit(wbAdr, REG_OFFSET)) begin
                offset_next[7:0] = wbDatIn[7:0];
            end
            if (hit(wbAdr, REG_IRQ_STAT)) begin
                stat_next = stat_reg & ~wbDatIn[1:0];
            end
            if (hit(wbAdr, REG_IRQ_MASK)) begin
                mask_next = wbDatIn[1:0];
            end
        end
        if (wrStrobe && wbSel[1] && hit(wbAdr, REG_OFFSET)) begin
            offset_next[15:8] = wbDatIn[15:8];
        end
        // a new failure wins over a clear in the same cycle
        stat_next = stat_next | fail;
        irq_next = |(stat_reg & mask_reg);
        ack_next = wbCyc && wbStb && !ack_reg;
        rdata_next = rdStrobe ? rdMux : 32'h00000000;
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg <= CTRL_RESET;
            offset_reg <= OFFSET_RESET;
            stat_reg <= 2'h0;
            mask_reg <= 2'h0;
            supA_reg <= '0;
            supB_reg <= '0;
            tempHi_reg <= '0;
            tempLo_reg <= '0;
            period_reg <= '0;
            winStart_reg <= 1'b0;
            ack_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            irq_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            offset_reg <= offset_next;
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            supA_reg <= supA_next;
            supB_reg <= supB_next;
            tempHi_reg <= tempHi_next;
            tempLo_reg <= tempLo_next;
            period_reg <= period_next;
            winStart_reg <= winStart_next;
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
            irq_reg <= irq_next;
        end
    end

    assign wbAck = ack_reg;
    assign wbDatOut = rdata_reg;
    assign irq = irq_reg;
endmodule
`default_nettype wire

/* dcvm_monitor_test.sv */
// self-checking bench: registers, interrupt and random dynamic check periods
`timescale 1ns/100ps
`default_nettype none
module dcvm_monitor_test import dcvm_pkg::*;;
    localparam int PER = 2000;
    logic clk = 1'b0, resetn = 1'b0, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
    logic glitch = 1'b0, tempValid = 1'b0, off = 1'b0, wbAck, irq, sValid, b6A, b6B;
    logic [7:0] wbAdr = 8'h0, tHi = 8'h0, tLo = 8'h0, supA = 8'hfc, supB = 8'hfc;
    logic [7:0] rdgA, rdgB, sA, sB;
    logic [31:0] wbDatIn = 32'h0, wbDatOut, rd, ex;
    logic [6:0] tgtA = 7'h02, tgtB = 7'h02, cA, cB;
    logic [5:0] pinsA, pinsB;
    logic [1:0] mode = 2'b00, mask = 2'b00;
    int failures = 0, checked = 0, cyc = 0, seed = 32'hd3f85d11, va, vb, up, lo;
    always #2 clk = ~clk;
    always @(posedge clk) if (resetn) cyc <= cyc + 1;
    dcvm_monitor #(.PERIOD_CYCLES(PER), .SAMPLE_CYCLES(4)) dcvm_monitor_i (.clk(clk),
        .resetn(resetn), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
        .wbSel(4'h3), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck),
        .cpuAVoltageCode(pinsA), .cpuBVoltageCode(pinsB), .seventhVoltageCodeBitA(b6A),
        .seventhVoltageCodeBitB(b6B), .supplyValid(sValid), .coreSupplyInputA(rdgA),
        .coreSupplyInputB(rdgB), .tempValid(tempValid), .tempCapableInputHi(tHi),
        .tempCapableInputLo(tLo), .irq(irq));
    dcvm_cpu_model dcvm_cpu_model_i (.clk(clk), .resetn(resetn), .target(tgtA),
        .glitch(glitch), .supply(supA), .codePins(pinsA), .bit6Pin(b6A), .reading(rdgA),
        .valid(sValid));
    dcvm_cpu_model dcvm_cpu_model_b_i (.clk(clk), .resetn(resetn), .target(tgtB),
        .glitch(glitch), .supply(supB), .codePins(pinsB), .bit6Pin(b6B), .reading(rdgB),
        .valid());
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDatIn <= dat;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        rd = wbDatOut;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge clk);
        if (n >= 20) begin
            failures++;
            finish_test();
        end
    endtask
    task automatic waitPhase(input int p);
        for (int n = 0; n <= PER && cyc % PER != p; n++)
            @(posedge clk);
        if (cyc % PER != p) begin
            failures++;
            finish_test();
        end
    endtask
    // code voltage in 6.25 mV units for the mode being set up
    function automatic int volt(input logic [6:0] c);
        return mode[1] ? 264 - int'(c) : 256 - 2 * int'(c[5:0]);
    endfunction
    function automatic logic failExp(input int v, input logic [7:0] r);
        return (v + up <= 254 && r > v + up) || (v >= lo && r < v - lo);
    endfunction
    function automatic logic [7:0] near(input int v);
        int r;
        r = v + $random(seed) % 24;
        return 8'((r > 255) ? 255 : (r < 0) ? 0 : r);
    endfunction
    // small moves only, so every ramp settles before the next window
    function automatic logic [6:0] stepTo(input logic [6:0] c);
        int n;
        n = int'(c[5:0]) + $random(seed) % 4;
        n = (n < 1) ? 1 : (n > 62) ? 62 : n;
        return {1'($random(seed)), 6'(n)};
    endfunction
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        wbXfer(1'b0, REG_OFFSET, 32'h0);
        check(rd, 32'(OFFSET_RESET));
        wbXfer(1'b1, 8'h20, 32'hffff);
        wbXfer(1'b0, 8'h20, 32'h0);
        check(rd, 32'h0);
        for (int i = 0; i < 4; i++) begin
            ex = 32'(i * 5);
            wbXfer(1'b1, REG_CTRL, ex);
            tHi <= 8'($random(seed));
            tLo <= 8'($random(seed));
            tempValid <= 1'b1;
            @(posedge clk);
            tempValid <= 1'b0;
            wbXfer(1'b0, REG_CTRL, 32'h0);
            check(rd, ex);
            wbXfer(1'b0, REG_TEMP, 32'h0);
            check(rd, {16'h0, tLo ^ {ex[3], 7'h0}, tHi ^ {ex[2], 7'h0}});
        end
        for (int k = 1; k <= 12; k++) begin
            waitPhase(1060);
            if (k > 1) begin
                wbXfer(1'b0, REG_IRQ_STAT, 32'h0);
                check(rd, ex);
                check(32'(irq), 32'(|(ex[1:0] & mask)));
                wbXfer(1'b0, k[0] ? REG_ERR_BMC : REG_ERR_HOST, 32'h0);
                check(rd, {28'h0, (mode == 2'b00) ? {tgtB[6], tgtA[6]} : 2'b00, ex[1:0]});
                wbXfer(1'b0, REG_AVG, 32'h0);
                if (!off)
                    check(rd, {6'h0, 10'(vb), 6'h0, 10'(va)});
            end
            wbXfer(1'b1, REG_IRQ_STAT, 32'h3);
            wbXfer(1'b0, REG_IRQ_STAT, 32'h0);
            check(rd, 32'h0);
            check(32'(irq), 32'h0);
            // 1: upper cap and masked flag, 2: off code, 3: skew glitch, then random
            mode = (k == 2) ? 2'b10 : (k == 1) ? 2'b00 : 2'($random(seed));
            up = 4 + ($random(seed) & 7);
            lo = 4 + ($random(seed) & 7);
            mask = (k == 1) ? 2'b01 : 2'($random(seed));
            cA = (k < 3) ? 7'h02 : stepTo(tgtA);
            cB = (k < 3) ? 7'h02 : stepTo(tgtB);
            va = volt(cA);
            vb = volt(cB);
            off = (k == 2);
            sA = (k == 1) ? 8'hff : off ? 8'h00 : near(va);
            sB = (k < 3) ? 8'(vb - lo - 1) : near(vb);
            ex = {30'h0, failExp(vb, sB), !off && failExp(va, sA)};
            tgtA <= cA;
            tgtB <= cB;
            supA <= sA;
            supB <= sB;
            wbXfer(1'b1, REG_OFFSET, {16'h0, lo[7:0], up[7:0]});
            wbXfer(1'b1, REG_CTRL, 32'(mode));
            wbXfer(1'b1, REG_IRQ_MASK, 32'(mask));
            if (k == 2) begin
                waitPhase(300);
                tgtA <= 7'h00;
                waitPhase(800);
                tgtA <= 7'h02;
            end
            if (k == 3) begin
                waitPhase(500);
                glitch <= 1'b1;
                @(posedge clk);
                glitch <= 1'b0;
            end
        end
        finish_test();
    end
endmodule
`default_nettype wire

/* dcvm_pkg.sv */
// shared constants and types for the dynamic core voltage monitor
package dcvm_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int CMP_PERIOD_NS = 100_000_000;
    localparam int CMP_CYCLES = CMP_PERIOD_NS / CLK_PERIOD_NS;
    localparam int AVG_WINDOW_NS = 1_500_000;
    localparam int AVG_CYCLES = AVG_WINDOW_NS / CLK_PERIOD_NS;
    localparam int AVG_SHIFT = 8;
    localparam int AVG_SAMPLES = 1 << AVG_SHIFT;
    localparam int AVG_SAMPLE_CYCLES = AVG_CYCLES / AVG_SAMPLES;
    localparam int SKEW_NS = 400;
    localparam int SKEW_CYCLES = (SKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ----------------------------------------
    // voltage scale
    // ----------------------------------------
    localparam int VOLT_W = 10;
    localparam int VOLT_LSB_UV = 6250;
    localparam int UPPER_CAP_UV = 1_587_500;
    localparam logic [VOLT_W:0] UPPER_CAP = 11'(UPPER_CAP_UV / VOLT_LSB_UV);
    localparam int ADC_W = 8;
    localparam logic [6:0] VID_OFF6 = 7'h3f;
    localparam logic [6:0] VID_OFF7 = 7'h00;
    localparam logic [7:0] SIGN_FLIP = 8'h80;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_OFFSET = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
    localparam logic [7:0] REG_ERR_HOST = 8'h10;
    localparam logic [7:0] REG_ERR_BMC = 8'h14;
    localparam logic [7:0] REG_AVG = 8'h18;
    localparam logic [7:0] REG_TEMP = 8'h1c;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_TEMP_HI = 2;
    localparam int CTRL_TEMP_LO = 3;
    localparam int OFS_UP_LSB = 0;
    localparam int OFS_LOW_LSB = 8;
    localparam int ERR_GPI_LSB = 2;
    localparam int AVG_B_LSB = 16;
    localparam int TEMP_LO_LSB = 8;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [15:0] OFFSET_RESET = 16'h0808;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {
        DCVM_MODE_LEGACY = 2'b00,
        DCVM_MODE_EXT = 2'b01,
        DCVM_MODE_SEVEN = 2'b10,
        DCVM_MODE_SEVEN_ALT = 2'b11
    } dcvm_mode_t;
    typedef enum logic [1:0] {
        DCVM_WIN_IDLE = 2'b00,
        DCVM_WIN_RUN = 2'b01,
        DCVM_WIN_DONE = 2'b10
    } dcvm_win_t;
endpackage

/* dcvm_vid_filter.sv */
// voltage code synchroniser, skew filter and window averager for one processor
`timescale 1ns/100ps
`default_nettype none
module dcvm_vid_filter import dcvm_pkg::*; #(
    parameter int SAMPLE_CYCLES = AVG_SAMPLE_CYCLES,
    parameter logic [VOLT_W-1:0] BASE6 = 10'h100,
    parameter logic [VOLT_W-1:0] BASE7 = 10'h108
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // pins
    input wire logic [5:0] codePins,
    input wire logic bit6Pin,
    // to main
    dcvm_vid_if.filt vidBus
);
    localparam int SW = $clog2(SAMPLE_CYCLES + 1);
    localparam int NW = AVG_SHIFT + 1;
    localparam int SUMW = VOLT_W + AVG_SHIFT;

    function automatic logic [VOLT_W-1:0] voltsOf(input logic [6:0] c, input dcvm_mode_t m);
        logic [VOLT_W-1:0] step;
        step = '0;
        if (m == DCVM_MODE_LEGACY || m == DCVM_MODE_EXT) begin
            step = VOLT_W'({c[5:0], 1'b0});
            voltsOf = (step > BASE6) ? '0 : BASE6 - step;
        end else begin
            step = VOLT_W'(c);
            voltsOf = (step > BASE7) ? '0 : BASE7 - step;
        end
    endfunction

    logic [6:0] sync1_reg, sync2_reg;
    logic [6:0] cand_reg, cand_next, code_reg, code_next;
    logic [6:0] stable_reg, stable_next;
    logic [6:0] pinCode;
    dcvm_win_t state_reg, state_next;
    logic [SW-1:0] tick_reg, tick_next;
    logic [NW-1:0] count_reg, count_next;
    logic [SUMW-1:0] sum_reg, sum_next;
    logic [VOLT_W-1:0] avg_reg, avg_next;
    logic off_reg, off_next, offAcc_reg, offAcc_next, done_reg, done_next;

    // legacy mode keeps the seventh pin out of the code
    assign pinCode = (vidBus.mode == DCVM_MODE_SEVEN || vidBus.mode == DCVM_MODE_SEVEN_ALT) ?
        sync2_reg : {1'b0, sync2_reg[5:0]};
    assign vidBus.avg = avg_reg;
    assign vidBus.offSeen = off_reg;
    assign vidBus.done = done_reg;
    assign vidBus.gpiLevel = sync2_reg[6];

    always_comb begin
        cand_next = cand_reg;
        code_next = code_reg;
        stable_next = stable_reg;
        // a code is accepted only after it stood still longer than line skew
        if (pinCode != cand_reg) begin
            cand_next = pinCode;
            stable_next = '0;
        end else if (stable_reg == 7'(SKEW_CYCLES - 1)) begin
            code_next = cand_reg;
        end else begin
            stable_next = stable_reg + 7'h01;
        end
        state_next = state_reg;
        tick_next = tick_reg;
        count_next = count_reg;
        sum_next = sum_reg;
        avg_next = avg_reg;
        off_next = off_reg;
        offAcc_next = offAcc_reg;
        done_next = 1'b0;
        case (state_reg)
            DCVM_WIN_IDLE: begin
                if (vidBus.winStart) begin
                    state_next = DCVM_WIN_RUN;
                    tick_next = '0;
                    count_next = '0;
                    sum_next = '0;
                    offAcc_next = 1'b0;
                end
            end
            DCVM_WIN_RUN: begin
                if ((vidBus.mode == DCVM_MODE_SEVEN || vidBus.mode == DCVM_MODE_SEVEN_ALT) ?
                        code_reg == VID_OFF7 : code_reg == VID_OFF6) begin
                    offAcc_next = 1'b1;
                end
                if (tick_reg == SW'(SAMPLE_CYCLES - 1)) begin
                    tick_next = '0;
                    sum_next = sum_reg + SUMW'(voltsOf(code_reg, vidBus.mode));
                    count_next = count_reg + NW'(1);
                    if (count_reg == NW'(AVG_SAMPLES - 1)) begin
                        state_next = DCVM_WIN_DONE;
                    end
                end else begin
                    tick_next = tick_reg + SW'(1);
                end
            end
            DCVM_WIN_DONE: begin
                avg_next = sum_reg[SUMW-1:AVG_SHIFT];
                off_next = offAcc_reg;
                done_next = 1'b1;
                state_next = DCVM_WIN_IDLE;
            end
            default: state_next = DCVM_WIN_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            cand_reg <= '0;
            code_reg <= '0;
            stable_reg <= '0;
            state_reg <= DCVM_WIN_IDLE;
            tick_reg <= '0;
            count_reg <= '0;
            sum_reg <= '0;
            avg_reg <= '0;
            off_reg <= 1'b0;
            offAcc_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            sync1_reg <= {bit6Pin, codePins};
            sync2_reg <= sync1_reg;
            cand_reg <= cand_next;
            code_reg <= code_next;
            stable_reg <= stable_next;
            state_reg <= state_next;
            tick_reg <= tick_next;
            count_reg <= count_next;
            sum_reg <= sum_next;
            avg_reg <= avg_next;
            off_reg <= off_next;
            offAcc_reg <= offAcc_next;
            done_reg <= done_next;
        end
    end
endmodule
`default_nettype wire

/* dcvm_vid_if.sv */
// link between the main monitor and one voltage code filter
`timescale 1ns/100ps
`default_nettype none
interface dcvm_vid_if import dcvm_pkg::*;;
    logic winStart;
    dcvm_mode_t mode;
    logic [VOLT_W-1:0] avg;
    logic offSeen;
    logic done;
    logic gpiLevel;
    modport filt(input winStart, input mode, output avg, output offSeen, output done,
        output gpiLevel);
    modport core(output winStart, output mode, input avg, input offSeen, input done,
        input gpiLevel);
endinterface
`default_nettype wire
